// >>> design/uotg_map.svh
`ifndef UOTG_MAP_SVH
`define UOTG_MAP_SVH

// Register byte offsets
`define UOTG_OFS_IFM_RESET     8'h00
`define UOTG_OFS_DEV_ADDR      8'h08
`define UOTG_OFS_OTG_CONTROL   8'h10
`define UOTG_OFS_OTG_STATUS    8'h14
`define UOTG_OFS_SERIAL_CTRL   8'h18
`define UOTG_OFS_LINE_FLAGS    8'h1c
`define UOTG_OFS_STICKY_MASK   8'h20

// On-the-go control fields
`define UOTG_OTG_EXT_VBUS_IND  7
`define UOTG_OTG_EXT_VBUS_DRV  6
`define UOTG_OTG_CHRG_VBUS     4
`define UOTG_OTG_DISCHRG_VBUS  3
`define UOTG_OTG_DM_PULLDOWN   2
`define UOTG_OTG_DP_PULLDOWN   1
`define UOTG_OTG_ID_PULLUP     0
`define UOTG_OTG_WR_MASK       8'hdf
`define UOTG_OTG_RESET         8'h00

// Serial control fields
`define UOTG_SER_RX_DIFF       6
`define UOTG_SER_RX_DM         5
`define UOTG_SER_RX_DP         4
`define UOTG_SER_TX_SE0        3
`define UOTG_SER_TX_DAT        2
`define UOTG_SER_TX_EN_N       1
`define UOTG_SER_FSLS          0
`define UOTG_SER_RESET         4'h2

// Line and error flag positions
`define UOTG_FLG_TOKEN_OK      6
`define UOTG_FLG_SE0           5
`define UOTG_FLG_K             4
`define UOTG_FLG_J             3
`define UOTG_FLG_CRC16_ERR     2
`define UOTG_FLG_RX_ACTIVE     1
`define UOTG_FLG_RX_ERROR      0
`define UOTG_FLG_FOLLOW_MASK   7'h03
`define UOTG_FLG_RESET         7'h00

// Line state codes on the transceiver
`define UOTG_LS_SE0            2'h0
`define UOTG_LS_J              2'h1
`define UOTG_LS_K              2'h2
`define UOTG_LS_NONE           2'h3

`define UOTG_DEV_ADDR_RESET    7'h00
`define UOTG_STICKY_RESET      7'h00

`endif

// >>> design/uotg_pkg.sv
package uotg_pkg;
  typedef logic [6:0]  uotg_flags_t;
  typedef logic [6:0]  uotg_addr_t;
  typedef logic [5:0]  uotg_status_t;
  typedef logic [31:0] uotg_word_t;
  typedef enum logic {UOTG_PKT_IDLE, UOTG_PKT_BUSY} uotg_pkt_state_t;
endpackage : uotg_pkg

// >>> design/uotg_flag_if.sv
interface uotg_flag_if;
  uotg_pkg::uotg_flags_t evt;
  uotg_pkg::uotg_flags_t lvl;
  uotg_pkg::uotg_flags_t sticky;
  uotg_pkg::uotg_flags_t sw_clr;
  logic                  pkt_start;
  logic                  ifm_reset;
  uotg_pkg::uotg_flags_t q;

  modport ctrl (output evt, lvl, sticky, sw_clr, pkt_start, ifm_reset, input q);
  modport bank (input evt, lvl, sticky, sw_clr, pkt_start, ifm_reset, output q);
endinterface : uotg_flag_if

// >>> design/uotg_flag_bank.sv
`include "uotg_map.svh"

module uotg_flag_bank #(
  parameter int         W      = 7,
  parameter logic [6:0] FOLLOW = `UOTG_FLG_FOLLOW_MASK
) (
  input wire logic clk,   // System clock
  input wire logic rst_n, // Synchronised reset, active low
  uotg_flag_if.bank f     // Flag controls and state
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic bit_reg;
      logic bit_next;

      always_comb begin
        bit_next = bit_reg;
        if (f.pkt_start && !f.sticky[i]) begin
          bit_next = 1'b0;
        end
        if (f.sw_clr[i]) begin
          bit_next = 1'b0;
        end
        if (FOLLOW[i]) begin
          // Plain bits track the input; sticky ones latch a high
          if (!f.sticky[i]) begin
            bit_next = f.lvl[i];
          end else if (f.lvl[i]) begin
            bit_next = 1'b1;
          end
        end else if (f.evt[i]) begin
          bit_next = 1'b1; // Set wins over packet and software clear
        end
        if (f.ifm_reset) begin
          bit_next = 1'b0;
        end
      end

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          bit_reg <= 1'b0;
        end else begin
          bit_reg <= bit_next;
        end
      end

      assign f.q[i] = bit_reg;
    end
  endgenerate

endmodule : uotg_flag_bank

// >>> design/uotg_regs.sv
`include "uotg_map.svh"

// Notes on behaviour
// - Bit 7 selects external VBUS valid indicator
// - Bit 6 requests external VBUS supply drive
// - Bits 4,3 drive charge/discharge VBUS
// - Bits 2,1 drive D-minus/D-plus pulldowns
// - Bit 0 enables ID pin pull-up
// - Status bits 5..0 mirror session signals
// - Serial bits 6..4 read receive lines
// - Serial bits 3,2 drive SE0/data transmit
// - Serial bit 1 active-low transmit enable, resets 1
// - Serial bit 0 selects serial interface mode
// - Flags 6..2 clear at next packet unless sticky
// - Sticky flags hold until software clears
// - Flag 6 set on valid addressed token
// - Flags 5,4,3 set on SE0, K, J
// - Flag 2 set on data CRC16 failure
// - Flags 1,0 follow receive active/error
// - Sticky mask bit holds flag until 1 written
// - Token address compared to 7-bit device address
module uotg_regs (
  input  wire logic        clk,              // 100 MHz system clock
  input  wire logic        rst_n,            // Async reset, active low
  input  wire logic [7:0]  addr,             // Register byte address
  input  wire logic [31:0] wr_data,          // Write data
  input  wire logic        wr_en,            // Write strobe
  input  wire logic        rd_en,            // Read strobe
  output logic      [31:0] rd_data,          // Read data, cycle after strobe
  input  wire logic        vbus_valid_int,   // Internal comparator VBUS valid
  input  wire logic        vbus_valid_ext,   // External VBUS indicator
  input  wire logic        b_valid,          // Transceiver B-session valid
  input  wire logic        id_gnd,           // Transceiver ID grounded
  input  wire logic        host_disconnect,  // Transceiver host disconnect
  input  wire logic        sess_valid,       // Transceiver session valid
  input  wire logic        sess_end,         // Transceiver session end
  input  wire logic        rx_rcv,           // Serial differential receive
  input  wire logic        rx_dm,            // Serial D-minus receive
  input  wire logic        rx_dp,            // Serial D-plus receive
  input  wire logic [1:0]  line_state,       // Transceiver line state
  input  wire logic        rx_active,        // Transceiver receive active
  input  wire logic        rx_error,         // Transceiver receive error
  input  wire logic        token_valid,      // Token decoded, one-cycle pulse
  input  wire logic        token_crc5_ok,    // Token CRC5 passed
  input  wire logic        token_pid_ok,     // Token PID check passed
  input  wire logic [6:0]  token_addr,       // Token device address
  input  wire logic        data_crc16_fail,  // Data packet CRC16 fail pulse
  output logic             vbus_valid,       // Selected VBUS valid
  output logic             drv_vbus_ext,     // External VBUS drive request
  output logic             chrg_vbus,        // Charge VBUS request
  output logic             dischrg_vbus,     // Discharge VBUS request
  output logic             dm_pulldown,      // D-minus pulldown enable
  output logic             dp_pulldown,      // D-plus pulldown enable
  output logic             id_pullup,        // ID pin pull-up enable
  output logic             tx_se0,           // Serial SE0 transmit
  output logic             tx_dat,           // Serial transmit data
  output logic             tx_enable_n,      // Serial transmit enable, low
  output logic             fsls_serial,      // Serial interface select
  output logic             token_accept      // Addressed token passed on
);

  logic                          rst_meta_reg;
  logic                          rst_sync_reg;
  logic                          rst_sync_n;
  logic [7:0]                    otg_ctrl_reg;
  logic [3:0]                    ser_ctrl_reg;
  uotg_pkg::uotg_addr_t          dev_addr_reg;
  uotg_pkg::uotg_flags_t         sticky_reg;
  uotg_pkg::uotg_status_t        otg_stat_reg;
  logic [2:0]                    ser_rx_reg;
  logic [1:0]                    ls_reg;
  logic                          rx_active_reg;
  logic                          rx_error_reg;
  logic                          vbus_sel_reg;
  logic                          tok_ok_reg;
  logic                          crc16_reg;
  logic                          accept_reg;
  uotg_pkg::uotg_pkt_state_t     pkt_reg;
  uotg_pkg::uotg_pkt_state_t     pkt_next;
  uotg_pkg::uotg_word_t          rd_reg;
  uotg_pkg::uotg_word_t          rd_next;
  logic                          wr_otg;
  logic                          wr_ser;
  logic                          wr_addr;
  logic                          wr_sticky;
  logic                          wr_flags;
  logic                          ifm_reset;
  logic                          addr_hit;

  uotg_flag_if flags ();

  // Reset release through two stages
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign rst_sync_n = rst_sync_reg;

  // Write decode
  assign wr_otg    = wr_en && (addr == `UOTG_OFS_OTG_CONTROL);
  assign wr_ser    = wr_en && (addr == `UOTG_OFS_SERIAL_CTRL);
  assign wr_addr   = wr_en && (addr == `UOTG_OFS_DEV_ADDR);
  assign wr_sticky = wr_en && (addr == `UOTG_OFS_STICKY_MASK);
  assign wr_flags  = wr_en && (addr == `UOTG_OFS_LINE_FLAGS);
  assign ifm_reset = wr_en && (addr == `UOTG_OFS_IFM_RESET);

  // On-the-go control; bit 5 has no storage
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      otg_ctrl_reg <= `UOTG_OTG_RESET;
    end else if (wr_otg) begin
      otg_ctrl_reg <= wr_data[7:0] & `UOTG_OTG_WR_MASK;
    end
  end

  assign drv_vbus_ext = otg_ctrl_reg[`UOTG_OTG_EXT_VBUS_DRV];
  assign chrg_vbus    = otg_ctrl_reg[`UOTG_OTG_CHRG_VBUS];
  assign dischrg_vbus = otg_ctrl_reg[`UOTG_OTG_DISCHRG_VBUS];
  assign dm_pulldown  = otg_ctrl_reg[`UOTG_OTG_DM_PULLDOWN];
  assign dp_pulldown  = otg_ctrl_reg[`UOTG_OTG_DP_PULLDOWN];
  assign id_pullup    = otg_ctrl_reg[`UOTG_OTG_ID_PULLUP];

  // VBUS valid source; registered so the output is a flop
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      vbus_sel_reg <= 1'b0;
    end else if (otg_ctrl_reg[`UOTG_OTG_EXT_VBUS_IND]) begin
      vbus_sel_reg <= vbus_valid_ext;
    end else begin
      vbus_sel_reg <= vbus_valid_int;
    end
  end

  assign vbus_valid = vbus_sel_reg;

  // Session signal mirror, VBUS valid taken from the selected source
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      otg_stat_reg <= '0;
    end else begin
      otg_stat_reg <= {b_valid, id_gnd, host_disconnect,
                       vbus_sel_reg, sess_valid, sess_end};
    end
  end

  // Serial control; receive bits are read-only mirrors
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ser_ctrl_reg <= `UOTG_SER_RESET;
    end else if (wr_ser) begin
      ser_ctrl_reg <= wr_data[3:0];
    end
  end

  assign tx_se0      = ser_ctrl_reg[`UOTG_SER_TX_SE0];
  assign tx_dat      = ser_ctrl_reg[`UOTG_SER_TX_DAT];
  assign tx_enable_n = ser_ctrl_reg[`UOTG_SER_TX_EN_N];
  assign fsls_serial = ser_ctrl_reg[`UOTG_SER_FSLS];

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ser_rx_reg <= '0;
    end else begin
      ser_rx_reg <= {rx_rcv, rx_dm, rx_dp};
    end
  end

  // Device address; cleared by interface reset as it is manager state
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      dev_addr_reg <= `UOTG_DEV_ADDR_RESET;
    end else if (ifm_reset) begin
      dev_addr_reg <= `UOTG_DEV_ADDR_RESET;
    end else if (wr_addr) begin
      dev_addr_reg <= wr_data[6:0];
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sticky_reg <= `UOTG_STICKY_RESET;
    end else if (ifm_reset) begin
      sticky_reg <= `UOTG_STICKY_RESET;
    end else if (wr_sticky) begin
      sticky_reg <= wr_data[6:0];
    end
  end

  // Receive-side inputs sampled once; flags and packet edge use these
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      // Ignored code, so no line flag sets before the first real sample
      ls_reg        <= `UOTG_LS_NONE;
      rx_active_reg <= 1'b0;
      rx_error_reg  <= 1'b0;
      crc16_reg     <= 1'b0;
    end else begin
      ls_reg        <= line_state;
      rx_active_reg <= rx_active;
      rx_error_reg  <= rx_error;
      crc16_reg     <= data_crc16_fail;
    end
  end

  // Token acceptance: all checks plus address match
  assign addr_hit = (token_addr == dev_addr_reg);

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tok_ok_reg <= 1'b0;
      accept_reg <= 1'b0;
    end else begin
      tok_ok_reg <= token_valid && token_crc5_ok && token_pid_ok && addr_hit;
      accept_reg <= token_valid && token_crc5_ok && token_pid_ok && addr_hit;
    end
  end

  assign token_accept = accept_reg;

  // Packet start is the rising edge of receive active
  always_comb begin
    pkt_next = pkt_reg;
    case (pkt_reg)
      uotg_pkg::UOTG_PKT_IDLE: begin
        if (rx_active_reg) begin
          pkt_next = uotg_pkg::UOTG_PKT_BUSY;
        end
      end
      uotg_pkg::UOTG_PKT_BUSY: begin
        if (!rx_active_reg) begin
          pkt_next = uotg_pkg::UOTG_PKT_IDLE;
        end
      end
      default: begin
        pkt_next = uotg_pkg::UOTG_PKT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pkt_reg <= uotg_pkg::UOTG_PKT_IDLE;
    end else if (ifm_reset) begin
      pkt_reg <= uotg_pkg::UOTG_PKT_IDLE;
    end else begin
      pkt_reg <= pkt_next;
    end
  end

  // Flag bank hookup
  always_comb begin
    flags.evt                       = '0;
    flags.evt[`UOTG_FLG_TOKEN_OK]   = tok_ok_reg;
    flags.evt[`UOTG_FLG_SE0]        = (ls_reg == `UOTG_LS_SE0);
    flags.evt[`UOTG_FLG_K]          = (ls_reg == `UOTG_LS_K);
    flags.evt[`UOTG_FLG_J]          = (ls_reg == `UOTG_LS_J);
    flags.evt[`UOTG_FLG_CRC16_ERR]  = crc16_reg;
    flags.lvl                       = '0;
    flags.lvl[`UOTG_FLG_RX_ACTIVE]  = rx_active_reg;
    flags.lvl[`UOTG_FLG_RX_ERROR]   = rx_error_reg;
  end

  assign flags.sticky    = sticky_reg;
  assign flags.sw_clr    = wr_flags ? wr_data[6:0] : '0;
  assign flags.pkt_start = (pkt_reg == uotg_pkg::UOTG_PKT_IDLE) && rx_active_reg;
  assign flags.ifm_reset = ifm_reset;

  uotg_flag_bank #(
    .W      (7),
    .FOLLOW (`UOTG_FLG_FOLLOW_MASK)
  ) u_flags (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .f     (flags.bank)
  );

  // Read mux; unmapped and write-only addresses read zero
  always_comb begin
    rd_next = '0;
    if (rd_en) begin
      case (addr)
        `UOTG_OFS_OTG_CONTROL: begin
          rd_next[7:0] = otg_ctrl_reg;
        end
        `UOTG_OFS_OTG_STATUS: begin
          rd_next[5:0] = otg_stat_reg;
        end
        `UOTG_OFS_SERIAL_CTRL: begin
          rd_next[6:0] = {ser_rx_reg, ser_ctrl_reg};
        end
        `UOTG_OFS_LINE_FLAGS: begin
          rd_next[6:0] = flags.q;
        end
        `UOTG_OFS_DEV_ADDR: begin
          rd_next[6:0] = dev_addr_reg;
        end
        `UOTG_OFS_STICKY_MASK: begin
          rd_next[6:0] = sticky_reg;
        end
        default: begin
          rd_next = '0;
        end
      endcase
    end
  end

  // Read data stands one cycle only
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rd_reg <= '0;
    end else begin
      rd_reg <= rd_next;
    end
  end

  assign rd_data = rd_reg;

endmodule : uotg_regs

// >>> sim/uotg_checker.sv
module uotg_checker (
  input wire logic        clk,            // Clock
  input wire logic        rst_n,          // Reset, low
  input wire logic [7:0]  addr,           // Address
  input wire logic [31:0] wr_data,        // Write data
  input wire logic        wr_en,          // Write
  input wire logic        rd_en,          // Read
  input wire logic [31:0] rd_data,        // Read data
  input wire logic        vbus_valid_int, // Comparator
  input wire logic        vbus_valid_ext, // Indicator
  input wire logic        token_valid,    // Token
  input wire logic        token_crc5_ok,  // CRC5 ok
  input wire logic        token_pid_ok,   // PID ok
  input wire logic [6:0]  token_addr,     // Token address
  input wire logic        vbus_valid,     // VBUS valid
  input wire logic        drv_vbus_ext,   // Drive VBUS
  input wire logic        chrg_vbus,      // Charge
  input wire logic        dischrg_vbus,   // Discharge
  input wire logic        dm_pulldown,    // D- pulldown
  input wire logic        dp_pulldown,    // D+ pulldown
  input wire logic        id_pullup,      // ID pull-up
  input wire logic        tx_se0,         // Tx SE0
  input wire logic        tx_dat,         // Tx data
  input wire logic        tx_enable_n,    // Tx enable, low
  input wire logic        fsls_serial,    // Serial mode
  input wire logic        token_accept    // Accepted
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [1:0] up_reg;
  logic       ext_reg;
  logic [6:0] dev_reg;
  wire        live = (up_reg == 2'h3);
  wire  [5:0] otg  = {drv_vbus_ext, chrg_vbus, dischrg_vbus, dm_pulldown, dp_pulldown, id_pullup};

  // Waits out the design's two-flop reset tail
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) up_reg <= 2'h0;
    else if (!live) up_reg <= up_reg + 2'h1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ext_reg <= 1'b0;
    else if (wr_en && addr == 8'h10) ext_reg <= wr_data[7];
  end

  // Interface reset also forgets the address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) dev_reg <= 7'h00;
    else if (wr_en && addr == 8'h08) dev_reg <= wr_data[6:0];
    else if (wr_en && addr == 8'h00) dev_reg <= 7'h00;
  end

  property p_rd_unmapped;
    rd_en && (addr == 8'h04 || addr == 8'h0c || addr > 8'h20) |=> rd_data == 32'h0;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

  property p_otg_rd;
    rd_en && addr == 8'h10 |=> rd_data == {24'h0, $past(ext_reg), $past(otg[5]), 1'b0, $past(otg[4:0])};
  endproperty
  a_otg_rd: assert property (p_otg_rd) else $error("otg readback wrong");

  property p_otg_wr;
    wr_en && addr == 8'h10 |=> otg == {$past(wr_data[6]), $past(wr_data[4:0])};
  endproperty
  a_otg_wr: assert property (p_otg_wr) else $error("otg pins not written");

  property p_otg_hold;
    !(wr_en && addr == 8'h10) |=> $stable(otg);
  endproperty
  a_otg_hold: assert property (p_otg_hold) else $error("otg pins moved");

  property p_ser_wr;
    wr_en && addr == 8'h18 |=> {tx_se0, tx_dat, tx_enable_n, fsls_serial} == $past(wr_data[3:0]);
  endproperty
  a_ser_wr: assert property (p_ser_wr) else $error("serial pins not written");

  property p_vbus_sel;
    live && ext_reg == $past(ext_reg) |-> vbus_valid == $past(ext_reg ? vbus_valid_ext : vbus_valid_int);
  endproperty
  a_vbus_sel: assert property (p_vbus_sel) else $error("vbus source wrong");

  property p_tok_ok;
    live && token_valid && token_crc5_ok && token_pid_ok && token_addr == dev_reg |=> token_accept;
  endproperty
  a_tok_ok: assert property (p_tok_ok) else $error("good token dropped");

  property p_tok_only;
    token_accept |-> $past(token_valid && token_crc5_ok && token_pid_ok && token_addr == dev_reg);
  endproperty
  a_tok_only: assert property (p_tok_only) else $error("bad token passed");

  c_otg_wr: cover property (wr_en && addr == 8'h10);
  c_tok: cover property (token_accept);
  c_flag_rd: cover property (rd_en && addr == 8'h1c);
endmodule : uotg_checker

// >>> sim/uotg_xcvr_model.sv
module uotg_xcvr_model (
  input  wire logic       fsls_serial, // Serial mode
  input  wire logic       tx_enable_n, // Tx enable, low
  input  wire logic       tx_se0,      // Tx SE0
  input  wire logic       tx_dat,      // Tx data
  output logic      [4:0] sess,        // Session lines
  output logic            vbus_int,    // Comparator
  output logic            vbus_ext,    // Indicator
  output logic      [2:0] rx_lines,    // Rcv, dm, dp
  output logic      [1:0] line_state,  // Line state
  output logic            rx_active,   // Rx active
  output logic            rx_error     // Rx error
);
  logic [2:0] idle_rx;

  // Transmit shows up on the receivers, as on the real line
  always_comb begin
    if (fsls_serial && !tx_enable_n) rx_lines = {tx_dat, !tx_se0 && !tx_dat, !tx_se0 && tx_dat};
    else rx_lines = idle_rx;
  end

  // Line state 3 is ignored, so no flag sets out of reset
  initial begin
    sess = 5'h00;
    vbus_int = 1'b0;
    vbus_ext = 1'b0;
    idle_rx = 3'h0;
    line_state = 2'h3;
    rx_active = 1'b0;
    rx_error = 1'b0;
  end

  task automatic put(input logic [4:0] s, input logic vi, ve, input logic [2:0] rl,
                     input logic [1:0] ls, input logic ra, re);
    sess <= s;
    vbus_int <= vi;
    vbus_ext <= ve;
    idle_rx <= rl;
    line_state <= ls;
    rx_active <= ra;
    rx_error <= re;
  endtask : put
endmodule : uotg_xcvr_model

// >>> sim/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic        token_valid = 1'b0;
  logic        token_crc5_ok = 1'b0;
  logic        token_pid_ok = 1'b0;
  logic [6:0]  token_addr = 7'h00;
  logic        data_crc16_fail = 1'b0;
  wire  [31:0] rd_data;
  wire  [1:0]  line_state;
  wire         vbus_valid_int, vbus_valid_ext, rx_rcv, rx_dm, rx_dp, rx_active, rx_error;
  wire         b_valid, id_gnd, host_disconnect, sess_valid, sess_end, token_accept;
  wire         vbus_valid, drv_vbus_ext, chrg_vbus, dischrg_vbus, dm_pulldown, dp_pulldown;
  wire         id_pullup, tx_se0, tx_dat, tx_enable_n, fsls_serial;
  wire  [5:0]  otg_pins = {drv_vbus_ext, chrg_vbus, dischrg_vbus, dm_pulldown, dp_pulldown, id_pullup};
  wire  [3:0]  ser_pins = {tx_se0, tx_dat, tx_enable_n, fsls_serial};
  int          n_fail = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  logic [4:0]  ses = 5'h00;
  logic        vi = 1'b0, ve = 1'b0, ra = 1'b0, re = 1'b0, c, p;
  logic [2:0]  rl = 3'h0;
  logic [1:0]  ls = 2'h3;
  logic [6:0]  ta;
  logic [31:0] d;

  uotg_regs uotg_regs_i (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .vbus_valid_int(vbus_valid_int), .vbus_valid_ext(vbus_valid_ext),
    .b_valid(b_valid), .id_gnd(id_gnd), .host_disconnect(host_disconnect),
    .sess_valid(sess_valid), .sess_end(sess_end), .rx_rcv(rx_rcv), .rx_dm(rx_dm), .rx_dp(rx_dp),
    .line_state(line_state), .rx_active(rx_active), .rx_error(rx_error),
    .token_valid(token_valid), .token_crc5_ok(token_crc5_ok), .token_pid_ok(token_pid_ok),
    .token_addr(token_addr), .data_crc16_fail(data_crc16_fail), .vbus_valid(vbus_valid),
    .drv_vbus_ext(drv_vbus_ext), .chrg_vbus(chrg_vbus), .dischrg_vbus(dischrg_vbus),
    .dm_pulldown(dm_pulldown), .dp_pulldown(dp_pulldown), .id_pullup(id_pullup),
    .tx_se0(tx_se0), .tx_dat(tx_dat), .tx_enable_n(tx_enable_n), .fsls_serial(fsls_serial),
    .token_accept(token_accept));

  uotg_xcvr_model uotg_xcvr_model_i (
    .fsls_serial(fsls_serial), .tx_enable_n(tx_enable_n), .tx_se0(tx_se0), .tx_dat(tx_dat),
    .sess({b_valid, id_gnd, host_disconnect, sess_valid, sess_end}), .vbus_int(vbus_valid_int),
    .vbus_ext(vbus_valid_ext), .rx_lines({rx_rcv, rx_dm, rx_dp}), .line_state(line_state),
    .rx_active(rx_active), .rx_error(rx_error));

  always #5 clk = ~clk;

  task automatic give_verdict();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  // Whole run is well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= v;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(nm, exp, rd_data);
  endtask : rd

  task automatic drv();
    @(posedge clk);
    uotg_xcvr_model_i.put(ses, vi, ve, rl, ls, ra, re);
  endtask : drv

  task automatic tok(input logic e);
    @(posedge clk);
    token_valid <= 1'b1;
    token_crc5_ok <= c;
    token_pid_ok <= p;
    token_addr <= ta;
    @(posedge clk);
    token_valid <= 1'b0;
    #1;
    chk("token_accept", {31'h0, e}, {31'h0, token_accept});
  endtask : tok

  function automatic logic [31:0] exp_ser(input logic [3:0] cv, input logic [2:0] r);
    logic [2:0] x;
    x = (cv[0] && !cv[1]) ? {cv[2], !cv[3] && !cv[2], !cv[3] && cv[2]} : r;
    return {25'h0, x, cv};
  endfunction : exp_ser

  function automatic logic [31:0] exp_st(input logic [4:0] s, input logic v);
    return {26'h0, s[4:2], v, s[1:0]};
  endfunction : exp_st

  initial begin
    void'($urandom(32'h2eb4f800));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("tx_enable_n", 32'h1, {31'h0, tx_enable_n});
    rd(8'h10, 32'h0, "otg_control");
    rd(8'h18, 32'h2, "serial_mode_control");
    rd(8'h3c, 32'h0, "unmapped");
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 32'hffffffff : $urandom;
      wr(8'h10, d);
      chk("otg_pins", {26'h0, d[6], d[4:0]}, {26'h0, otg_pins});
      rd(8'h10, d & 32'hdf, "otg_control");
    end
    for (int i = 0; i < 8; i++) begin
      ses = 5'($urandom);
      vi = 1'($urandom);
      ve = 1'($urandom);
      drv();
      wr(8'h10, {24'h0, i[0], 7'h0});
      repeat (4) @(posedge clk);
      #1;
      chk("vbus_valid", {31'h0, i[0] ? ve : vi}, {31'h0, vbus_valid});
      rd(8'h14, exp_st(ses, i[0] ? ve : vi), "otg_status_flags");
      wr(8'h14, $urandom);
    end
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 32'h9 : (i == 1) ? 32'h5 : $urandom;
      rl = 3'($urandom);
      drv();
      wr(8'h18, d);
      chk("serial_pins", {28'h0, d[3:0]}, {28'h0, ser_pins});
      repeat (3) @(posedge clk);
      rd(8'h18, exp_ser(d[3:0], rl), "serial_mode_control");
    end
    wr(8'h18, 32'h2);
    rd(8'h1c, 32'h0, "line_error_flags");
    for (int i = 0; i < 3; i++) begin
      ls = 2'(i);
      drv();
      repeat (2) @(posedge clk);
    end
    ls = 2'h3;
    drv();
    data_crc16_fail <= 1'b1;
    @(posedge clk);
    data_crc16_fail <= 1'b0;
    rd(8'h1c, 32'h3c, "line_error_flags");
    wr(8'h1c, 32'h0c);
    rd(8'h1c, 32'h30, "line_error_flags");
    wr(8'h20, 32'h21);
    ra = 1'b1;
    re = 1'b1;
    drv();
    repeat (3) @(posedge clk);
    rd(8'h1c, 32'h23, "line_error_flags");
    ra = 1'b0;
    re = 1'b0;
    drv();
    repeat (3) @(posedge clk);
    rd(8'h1c, 32'h21, "line_error_flags");
    wr(8'h1c, 32'h21);
    rd(8'h1c, 32'h0, "line_error_flags");
    wr(8'h08, 32'h5a);
    for (int i = 0; i < 10; i++) begin
      {c, p} = (i == 0) ? 2'h3 : 2'($urandom);
      ta = (i == 0 || i[0]) ? 7'h5a : 7'($urandom);
      tok(c && p && ta == 7'h5a);
    end
    rd(8'h1c, 32'h40, "line_error_flags");
    wr(8'h00, $urandom);
    rd(8'h08, 32'h0, "device_address");
    rd(8'h20, 32'h0, "flag_stickiness_mask");
    {c, p} = 2'h3;
    ta = 7'h00;
    tok(1'b1);
    give_verdict();
  end
endmodule : tb_top

bind uotg_regs uotg_checker uotg_checker_i (
  .clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
  .rd_data(rd_data), .vbus_valid_int(vbus_valid_int), .vbus_valid_ext(vbus_valid_ext),
  .token_valid(token_valid), .token_crc5_ok(token_crc5_ok), .token_pid_ok(token_pid_ok),
  .token_addr(token_addr), .vbus_valid(vbus_valid), .drv_vbus_ext(drv_vbus_ext),
  .chrg_vbus(chrg_vbus), .dischrg_vbus(dischrg_vbus), .dm_pulldown(dm_pulldown),
  .dp_pulldown(dp_pulldown), .id_pullup(id_pullup), .tx_se0(tx_se0), .tx_dat(tx_dat),
  .tx_enable_n(tx_enable_n), .fsls_serial(fsls_serial), .token_accept(token_accept));
